// ===== shared/ulc_consts.svh
/*
  Register offsets, field positions, reset values and frame format figures for
  one serial channel's configuration block.
  Assumes inclusion by bare name from the rtl files.
*/
`ifndef ULC_CONSTS_SVH
`define ULC_CONSTS_SVH

`define ULC_AW              4
`define ULC_DW              8

`define ULC_OFF_DATA        4'h0
`define ULC_OFF_DIVH        4'h1
`define ULC_OFF_FIFO        4'h2
`define ULC_OFF_LINE        4'h3
`define ULC_OFF_MODEM       4'h4
`define ULC_OFF_FEAT        4'h8
`define ULC_OFF_ENH         4'h9
`define ULC_OFF_RXPROG      4'ha
`define ULC_OFF_TXPROG      4'hb
`define ULC_OFF_STAT        4'hc
`define ULC_OFF_TXLVL       4'hd
`define ULC_OFF_RXLVL       4'he

`define ULC_FCR_EN          0
`define ULC_FCR_RXRST       1
`define ULC_FCR_TXRST       2
`define ULC_FCR_BLK         3
`define ULC_FCR_TXSEL       4
`define ULC_FCR_RXSEL       6

`define ULC_LCR_WLEN        0
`define ULC_LCR_STOP        2
`define ULC_LCR_PEN         3
`define ULC_LCR_EPS         4
`define ULC_LCR_FORCE       5
`define ULC_LCR_BRK         6
`define ULC_LCR_DLAB        7

`define ULC_MCR_DTR         0
`define ULC_MCR_RTS         1
`define ULC_MCR_FLOWSEL     2

`define ULC_FEATURE_CONTROL_TBL        6
`define ULC_EFR_ENH         4
`define ULC_EFR_AUTORTS     6

`define ULC_RST_LCR         8'h00
`define ULC_RST_MCR         8'h00
`define ULC_RST_FEAT        8'h00
`define ULC_RST_ENH         8'h00
`define ULC_RST_PROG        8'h01
`define ULC_RST_DIV         8'h00

`define ULC_WORD_MIN        4'h5
`define ULC_STOP_ONE        3'h2
`define ULC_STOP_ONEHALF    3'h3
`define ULC_STOP_TWO        3'h4

`endif

// ===== shared/ulc_pkg.sv
/*
  Types shared by the channel configuration block.
  Assumes the constants header sits beside it on the include path.
*/
package ulc_pkg;

  typedef enum logic [1:0] {
    ULC_TBL_A = 2'h0,
    ULC_TBL_B = 2'h1,
    ULC_TBL_C = 2'h2,
    ULC_TBL_D = 2'h3
  } ulc_table_t;

  typedef enum logic [2:0] {
    ULC_PAR_NONE  = 3'h0,
    ULC_PAR_ODD   = 3'h1,
    ULC_PAR_EVEN  = 3'h2,
    ULC_PAR_MARK  = 3'h3,
    ULC_PAR_SPACE = 3'h4
  } ulc_par_t;

endpackage

// ===== rtl/ulc_trigger_sel.sv
/*
  Trigger level lookup for the receive and transmit FIFOs.
  Assumes select codes and programmed levels come from the register file
  on the same clock; the output is purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ulc_consts.svh"

module ulc_trigger_sel
  import ulc_pkg::*;
#(
  parameter int LW = 8
) (
  // Selection
  input  wire ulc_table_t  table_sel,
  input  wire logic [1:0]  rx_code,
  input  wire logic [1:0]  tx_code,
  // Programmed levels
  input  wire logic [LW-1:0] rx_prog,
  input  wire logic [LW-1:0] tx_prog,
  // Levels
  output logic [LW-1:0]    rx_level,
  output logic [LW-1:0]    tx_level
);

  function automatic logic [LW-1:0] pick(input logic [1:0] c,
                                         input logic [7:0] l0,
                                         input logic [7:0] l1,
                                         input logic [7:0] l2,
                                         input logic [7:0] l3);
    logic [7:0] v;
    v = l0;
    case (c)
      2'h0: v = l0;
      2'h1: v = l1;
      2'h2: v = l2;
      default: v = l3;
    endcase
    return LW'(v);
  endfunction

  wire logic [LW-1:0] rx_a = pick(rx_code, 8'h01, 8'h04, 8'h08, 8'h0e);
  wire logic [LW-1:0] rx_b = pick(rx_code, 8'h08, 8'h10, 8'h18, 8'h1c);
  wire logic [LW-1:0] tx_b = pick(tx_code, 8'h10, 8'h08, 8'h18, 8'h1e);
  wire logic [LW-1:0] rx_c = pick(rx_code, 8'h08, 8'h10, 8'h38, 8'h3c);
  wire logic [LW-1:0] tx_c = pick(tx_code, 8'h08, 8'h10, 8'h20, 8'h38);

  // One table drives both directions.
  assign rx_level = (table_sel == ULC_TBL_A) ? rx_a :
                    (table_sel == ULC_TBL_B) ? rx_b :
                    (table_sel == ULC_TBL_C) ? rx_c :
                                               rx_prog;
  assign tx_level = (table_sel == ULC_TBL_A) ? LW'(1) :
                    (table_sel == ULC_TBL_B) ? tx_b :
                    (table_sel == ULC_TBL_C) ? tx_c :
                                               tx_prog;

endmodule
`default_nettype wire

// ===== rtl/ulc_frame_fmt.sv
/*
  Serial frame format decode and parity generation and checking.
  Assumes the transmitter and receiver hand over characters on the same
  clock; data bits above the word length are ignored here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ulc_consts.svh"

module ulc_frame_fmt
  import ulc_pkg::*;
(
  // Line control fields
  input  wire logic [7:0] line_ctl,
  // Characters
  input  wire logic [7:0] tx_char,
  input  wire logic [7:0] rx_char,
  input  wire logic       rx_par_bit,
  // Format
  output logic [3:0]      word_bits,
  output logic [2:0]      stop_half_bits,
  output ulc_par_t        par_mode,
  // Parity
  output logic            tx_par_bit,
  output logic            rx_par_err
);

  wire logic [1:0] wl_code = line_ctl[`ULC_LCR_WLEN +: 2];
  wire logic       stop_b  = line_ctl[`ULC_LCR_STOP];
  wire logic       pen     = line_ctl[`ULC_LCR_PEN];
  wire logic       eps     = line_ctl[`ULC_LCR_EPS];
  wire logic       force_p = line_ctl[`ULC_LCR_FORCE];

  function automatic logic par_of(input logic [7:0] d,
                                  input logic [1:0] wl,
                                  input ulc_par_t m);
    logic [7:0] mask;
    logic       x;
    mask = 8'hff >> (2'h3 - wl);
    x = ^(d & mask);
    case (m)
      ULC_PAR_ODD:  par_of = ~x;
      ULC_PAR_EVEN: par_of = x;
      ULC_PAR_MARK: par_of = 1'b1;
      default:      par_of = 1'b0;
    endcase
  endfunction

  assign word_bits = `ULC_WORD_MIN + {2'h0, wl_code};
  assign stop_half_bits = !stop_b ? `ULC_STOP_ONE :
                          (wl_code == 2'h0) ? `ULC_STOP_ONEHALF :
                          `ULC_STOP_TWO;

  assign par_mode = !pen ? ULC_PAR_NONE :
                    (force_p && !eps) ? ULC_PAR_MARK :
                    (force_p && eps) ? ULC_PAR_SPACE :
                    eps ? ULC_PAR_EVEN : ULC_PAR_ODD;

  assign tx_par_bit = par_of(tx_char, wl_code, par_mode);
  // No parity means no check is made.
  assign rx_par_err = (par_mode != ULC_PAR_NONE) &&
                      (rx_par_bit != par_of(rx_char, wl_code, par_mode));

endmodule
`default_nettype wire

// ===== rtl/ulc_top.sv
/*
  Configuration block of one serial channel: FIFO control, line control,
  modem control, feature and enhanced registers, divisor latch, trigger
  levels, transmit trigger request, break and the DTR and RTS outputs.
  Assumes a same-clock register master, a transmitter and receiver that
  consume the frame format, and FIFOs outside that report their counts.
*/
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ulc_consts.svh"

// Functional notes
// - Block-transfer mode bit stored, no behavioural effect.
// - Transmit request below trigger after a fill past it, otherwise when empty.
// - One trigger table serves both directions.
// - Tables A and B trigger levels.
// - Table C levels; table D programmed.
// - Table select field picks trigger table.
// - Word length five to eight bits.
// - Stop bits one, one and a half, or two.
// - Parity enable sends and checks parity.
// - Parity type selects odd or even.
// - Forced parity fixed mark or space.
// - Break holds transmit line low.
// - Divisor access bit redirects data locations.
// - DTR control bit drives low-active output.
// - Auto flow drives DTR when selected.
// - RTS control bit, or auto flow.
// - Flow select bit picks RTS or DTR.
module ulc_top
  import ulc_pkg::*;
#(
  parameter int LW = 8
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst,
  // Register port
  input  wire logic [3:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output var  logic [7:0]      reg_rdata,
  // Data register path
  input  wire logic [7:0]      rx_hold_data,
  output logic                 rx_pop,
  output var  logic            tx_push,
  output var  logic [7:0]      tx_push_data,
  // FIFO state and control
  input  wire logic [LW-1:0]   tx_fifo_count,
  input  wire logic [LW-1:0]   rx_fifo_count,
  output var  logic            fifo_enable,
  output var  logic            rx_fifo_clear,
  output var  logic            tx_fifo_clear,
  output var  logic            tx_trig_req,
  output var  logic            rx_trig_hit,
  // Frame format
  output logic [3:0]           word_bits,
  output logic [2:0]           stop_half_bits,
  output ulc_par_t             par_mode,
  input  wire logic [7:0]      tx_char,
  output logic                 tx_par_bit,
  input  wire logic [7:0]      rx_char,
  input  wire logic            rx_par_bit,
  output logic                 rx_par_err,
  // Baud divisor
  output var  logic [15:0]     baud_divisor,
  // Serial line
  input  wire logic            tx_serial_bit,
  output var  logic            tx_line,
  // Modem outputs
  output var  logic            dtr_n,
  output var  logic            rts_n
);

  // Register state.
  logic [7:0]    line_ctl_r;
  logic [7:0]    modem_ctl_r;
  logic [7:0]    feat_ctl_r;
  logic [7:0]    enh_feat_r;
  logic [LW-1:0] rx_prog_r;
  logic [LW-1:0] tx_prog_r;
  logic [7:0]    div_low_r;
  logic [7:0]    div_high_r;
  logic          fifo_en_r;
  logic          blk_mode_r;
  logic [1:0]    rx_code_r;
  logic [1:0]    tx_code_r;
  logic          filled_over_r;

  // Write and read decode.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction

  wire logic dlab     = line_ctl_r[`ULC_LCR_DLAB];
  wire logic wr_data  = reg_wr && hit(reg_addr, `ULC_OFF_DATA);
  wire logic rd_data  = reg_rd && hit(reg_addr, `ULC_OFF_DATA);
  wire logic wr_divh  = reg_wr && hit(reg_addr, `ULC_OFF_DIVH) && dlab;
  wire logic wr_divl  = wr_data && dlab;
  wire logic wr_thr   = wr_data && !dlab;
  wire logic wr_fifo  = reg_wr && hit(reg_addr, `ULC_OFF_FIFO);
  wire logic wr_line  = reg_wr && hit(reg_addr, `ULC_OFF_LINE);
  wire logic wr_modem = reg_wr && hit(reg_addr, `ULC_OFF_MODEM);
  wire logic wr_feat  = reg_wr && hit(reg_addr, `ULC_OFF_FEAT);
  wire logic wr_enh   = reg_wr && hit(reg_addr, `ULC_OFF_ENH);
  wire logic wr_rxp   = reg_wr && hit(reg_addr, `ULC_OFF_RXPROG);
  wire logic wr_txp   = reg_wr && hit(reg_addr, `ULC_OFF_TXPROG);

  // A FIFO write without its enable bit only turns the FIFOs off.
  wire logic fifo_prog = wr_fifo && reg_wdata[`ULC_FCR_EN];
  wire logic enh_on    = enh_feat_r[`ULC_EFR_ENH];
  wire logic tx_sel_ok = fifo_prog && enh_on;

  // Receive data is popped only while the data register is selected.
  assign rx_pop = rd_data && !dlab;

  // Trigger lookup.
  wire ulc_table_t table_sel =
    ulc_table_t'(feat_ctl_r[`ULC_FEATURE_CONTROL_TBL +: 2]);
  logic [LW-1:0] rx_level;
  logic [LW-1:0] tx_level;

  // Both directions share table_sel, so the latest selection rules both.
  ulc_trigger_sel #(
    .LW (LW)
  ) u_trig (
    .table_sel (table_sel),
    .rx_code   (rx_code_r),
    .tx_code   (tx_code_r),
    .rx_prog   (rx_prog_r),
    .tx_prog   (tx_prog_r),
    .rx_level  (rx_level),
    .tx_level  (tx_level)
  );

  // Frame format and parity.
  ulc_frame_fmt u_fmt (
    .line_ctl       (line_ctl_r),
    .tx_char        (tx_char),
    .rx_char        (rx_char),
    .rx_par_bit     (rx_par_bit),
    .word_bits      (word_bits),
    .stop_half_bits (stop_half_bits),
    .par_mode       (par_mode),
    .tx_par_bit     (tx_par_bit),
    .rx_par_err     (rx_par_err)
  );

  // Transmit trigger request.
  wire logic tx_empty   = (tx_fifo_count == '0);
  wire logic tx_below   = (tx_fifo_count < tx_level);
  wire logic tx_over    = (tx_fifo_count > tx_level);
  // Without a fill past the trigger, only an empty FIFO asks for data.
  wire logic tx_req_nxt = fifo_en_r &&
                          (filled_over_r ? tx_below : tx_empty);
  wire logic filled_nxt = tx_empty ? 1'b0 :
                          tx_over ? 1'b1 : filled_over_r;

  // Automatic flow control: ready while receive stays below trigger.
  wire logic auto_flow  = enh_feat_r[`ULC_EFR_AUTORTS];
  wire logic flow_sel   = modem_ctl_r[`ULC_MCR_FLOWSEL];
  wire logic flow_ok    = (rx_fifo_count < rx_level);
  wire logic auto_dtr   = auto_flow && flow_sel;
  wire logic auto_rts   = auto_flow && !flow_sel;
  wire logic dtr_n_nxt  = auto_dtr ? !flow_ok :
                          !modem_ctl_r[`ULC_MCR_DTR];
  wire logic rts_n_nxt  = auto_rts ? !flow_ok :
                          !modem_ctl_r[`ULC_MCR_RTS];

  // Status words.
  wire logic [7:0] stat_word = {2'h0, auto_flow, filled_over_r,
                                rx_trig_hit, tx_trig_req,
                                blk_mode_r, fifo_en_r};

  // Read selection; unmapped and write-only locations read zero.
  wire logic [7:0] rd_mux =
    hit(reg_addr, `ULC_OFF_DATA)   ? (dlab ? div_low_r : rx_hold_data) :
    hit(reg_addr, `ULC_OFF_DIVH)   ? (dlab ? div_high_r : 8'h00) :
    hit(reg_addr, `ULC_OFF_LINE)   ? line_ctl_r :
    hit(reg_addr, `ULC_OFF_MODEM)  ? modem_ctl_r :
    hit(reg_addr, `ULC_OFF_FEAT)   ? feat_ctl_r :
    hit(reg_addr, `ULC_OFF_ENH)    ? enh_feat_r :
    hit(reg_addr, `ULC_OFF_RXPROG) ? 8'(rx_prog_r) :
    hit(reg_addr, `ULC_OFF_TXPROG) ? 8'(tx_prog_r) :
    hit(reg_addr, `ULC_OFF_STAT)   ? stat_word :
    hit(reg_addr, `ULC_OFF_TXLVL)  ? 8'(tx_level) :
    hit(reg_addr, `ULC_OFF_RXLVL)  ? 8'(rx_level) :
                                     8'h00;

  // Read data and data-register strobes.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata    <= 8'h00;
      tx_push      <= 1'b0;
      tx_push_data <= 8'h00;
    end else begin
      reg_rdata    <= reg_rd ? rd_mux : 8'h00;
      tx_push      <= wr_thr;
      tx_push_data <= wr_thr ? reg_wdata : tx_push_data;
    end
  end

  // Line and modem control.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      line_ctl_r  <= `ULC_RST_LCR;
      modem_ctl_r <= `ULC_RST_MCR;
    end else begin
      if (wr_line) begin
        line_ctl_r <= reg_wdata;
      end
      if (wr_modem) begin
        modem_ctl_r <= reg_wdata;
      end
    end
  end

  // Feature, enhanced and programmed trigger registers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      feat_ctl_r <= `ULC_RST_FEAT;
      enh_feat_r <= `ULC_RST_ENH;
      rx_prog_r  <= LW'(`ULC_RST_PROG);
      tx_prog_r  <= LW'(`ULC_RST_PROG);
    end else begin
      if (wr_feat) begin
        feat_ctl_r <= reg_wdata;
      end
      if (wr_enh) begin
        enh_feat_r <= reg_wdata;
      end
      if (wr_rxp) begin
        rx_prog_r <= LW'(reg_wdata);
      end
      if (wr_txp) begin
        tx_prog_r <= LW'(reg_wdata);
      end
    end
  end

  // Divisor latch bytes.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_low_r  <= `ULC_RST_DIV;
      div_high_r <= `ULC_RST_DIV;
    end else begin
      if (wr_divl) begin
        div_low_r <= reg_wdata;
      end
      if (wr_divh) begin
        div_high_r <= reg_wdata;
      end
    end
  end

  // FIFO control fields.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fifo_en_r  <= 1'b0;
      blk_mode_r <= 1'b0;
      rx_code_r  <= 2'h0;
      tx_code_r  <= 2'h0;
    end else if (wr_fifo) begin
      fifo_en_r <= reg_wdata[`ULC_FCR_EN];
      if (fifo_prog) begin
        blk_mode_r <= reg_wdata[`ULC_FCR_BLK];
        rx_code_r  <= reg_wdata[`ULC_FCR_RXSEL +: 2];
      end
      if (tx_sel_ok) begin
        tx_code_r <= reg_wdata[`ULC_FCR_TXSEL +: 2];
      end
    end
  end

  // FIFO clear pulses last one cycle and need the enable bit.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_fifo_clear <= 1'b0;
      tx_fifo_clear <= 1'b0;
    end else begin
      rx_fifo_clear <= fifo_prog && reg_wdata[`ULC_FCR_RXRST];
      tx_fifo_clear <= fifo_prog && reg_wdata[`ULC_FCR_TXRST];
    end
  end

  // Trigger state.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      filled_over_r <= 1'b0;
      tx_trig_req   <= 1'b0;
      rx_trig_hit   <= 1'b0;
    end else begin
      filled_over_r <= filled_nxt;
      tx_trig_req   <= tx_req_nxt;
      rx_trig_hit   <= fifo_en_r && (rx_fifo_count >= rx_level);
    end
  end

  // Pins and exported settings.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_line      <= 1'b1;
      dtr_n        <= 1'b1;
      rts_n        <= 1'b1;
      fifo_enable  <= 1'b0;
      baud_divisor <= 16'h0000;
    end else begin
      // Break overrides whatever the transmitter is sending.
      tx_line      <= line_ctl_r[`ULC_LCR_BRK] ? 1'b0 :
                      tx_serial_bit;
      dtr_n        <= dtr_n_nxt;
      rts_n        <= rts_n_nxt;
      fifo_enable  <= fifo_en_r;
      baud_divisor <= {div_high_r, div_low_r};
    end
  end

endmodule
`default_nettype wire

// ===== tb/ulc_asserts.sv
/*
  Checker for the channel configuration block, bound to ulc_top.
  Assumes one clock; register state is mirrored from the write port.
*/
`timescale 1ns/1ps
`default_nettype none
module ulc_asserts #(
  parameter int LW = 8
) (
  // Clock, reset and register port
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Observed outputs
  input wire logic       tx_push,
  input wire logic [7:0] tx_push_data,
  input wire logic [3:0] word_bits,
  input wire logic [2:0] stop_half_bits,
  input wire logic       tx_serial_bit,
  input wire logic       tx_line,
  input wire logic       dtr_n,
  input wire logic       rts_n,
  input wire logic       rx_pop,
  input wire logic       rx_fifo_clear,
  input wire logic       tx_fifo_clear
);
  // Only the ports are visible, so the registers are shadowed here.
  logic [7:0] lcr_r;
  logic [7:0] mcr_r;
  logic [7:0] enh_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lcr_r <= 8'h00;
      mcr_r <= 8'h00;
      enh_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 4'h3) lcr_r <= reg_wdata;
      if (reg_addr == 4'h4) mcr_r <= reg_wdata;
      if (reg_addr == 4'h9) enh_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_BRK: assert property (lcr_r[6] |=> !tx_line)
    else $error("break did not hold the line low");
  AST_FOLLOW: assert property (!lcr_r[6] |=>
    tx_line == $past(tx_serial_bit)) else $error("line not resumed");
  AST_WORD: assert property (word_bits == 4'h5 + {2'b00, lcr_r[1:0]})
    else $error("word length wrong");
  AST_STOP: assert property (stop_half_bits ==
    (!lcr_r[2] ? 3'h2 : (lcr_r[1:0] == 2'h0 ? 3'h3 : 3'h4)))
    else $error("stop length wrong");
  AST_DTR: assert property ((!enh_r[6] || !mcr_r[2]) |=>
    dtr_n == !$past(mcr_r[0])) else $error("dtr pin wrong");
  AST_RTS: assert property ((!enh_r[6] || mcr_r[2]) |=>
    rts_n == !$past(mcr_r[1])) else $error("rts pin wrong");
  AST_PUSH: assert property (reg_wr && reg_addr == 4'h0 && !lcr_r[7]
    |=> tx_push && tx_push_data == $past(reg_wdata))
    else $error("data write not pushed");
  AST_RDBACK: assert property (reg_rd && reg_addr == 4'h3 |=>
    reg_rdata == $past(lcr_r)) else $error("line control readback wrong");
  AST_POP: assert property (rx_pop ==
    (reg_rd && reg_addr == 4'h0 && !lcr_r[7]))
    else $error("receive pop strobe wrong");
  AST_CLEAR: assert property (reg_wr && reg_addr == 4'h2 |=>
    rx_fifo_clear == ($past(reg_wdata[1]) && $past(reg_wdata[0])) &&
    tx_fifo_clear == ($past(reg_wdata[2]) && $past(reg_wdata[0])))
    else $error("fifo clear pulse wrong");
endmodule
bind ulc_top ulc_asserts #(.LW(LW)) i_asserts (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_push(tx_push), .tx_push_data(tx_push_data), .word_bits(word_bits),
  .stop_half_bits(stop_half_bits), .tx_serial_bit(tx_serial_bit),
  .tx_line(tx_line), .dtr_n(dtr_n), .rts_n(rts_n), .rx_pop(rx_pop),
  .rx_fifo_clear(rx_fifo_clear), .tx_fifo_clear(tx_fifo_clear)
);
`default_nettype wire

// ===== tb/ulc_remote_model.sv
/*
  Remote serial partner: sends characters whose parity follows the
  agreed format and feeds a changing bit to the transmit path.
  Assumes the block's clock and its frame format outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module ulc_remote_model
  import ulc_pkg::*;
(
  // Clock
  input  wire logic       clk_sys,
  // Agreed format and fault injection
  input  wire logic [3:0] word_bits,
  input  wire ulc_par_t   par_mode,
  input  wire logic       corrupt,
  // Line side
  output logic [7:0]      rx_char,
  output logic            rx_par_bit,
  output logic            tx_serial_bit
);
  logic ones;
  // Bits above the word length are left random so the block must mask.
  assign ones = ^(rx_char & (8'hff >> (4'h8 - word_bits)));
  always_comb begin
    case (par_mode)
      ULC_PAR_ODD:   rx_par_bit = ~ones ^ corrupt;
      ULC_PAR_EVEN:  rx_par_bit = ones ^ corrupt;
      ULC_PAR_MARK:  rx_par_bit = ~corrupt;
      ULC_PAR_SPACE: rx_par_bit = corrupt;
      default:       rx_par_bit = rx_char[0];
    endcase
  end
  always @(posedge clk_sys) begin
    rx_char <= 8'($urandom);
    tx_serial_bit <= 1'($urandom);
  end
endmodule
`default_nettype wire

// ===== tb/test_uart_line_fifo_modem_config.sv
/*
  Self-checking bench for the channel configuration block.
  Assumes the checker binds itself and the partner drives the line side.
*/
`timescale 1ns/1ps
`default_nettype none
module test_uart_line_fifo_modem_config;
  import ulc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  rx_hold = 8'h00;
  logic [7:0]  tx_cnt = 8'h00;
  logic [7:0]  rx_cnt = 8'h00;
  logic [7:0]  tx_char = 8'h00;
  logic        corrupt = 1'b0;
  logic [7:0]  reg_rdata, tx_push_data, rx_char, rd_v, v;
  logic        rx_par_bit, tx_serial_bit, tx_push, fifo_enable, tx_trig_req;
  logic        rx_trig_hit, tx_par_bit, rx_par_err, tx_line, dtr_n, rts_n;
  logic [3:0]  word_bits;
  logic [2:0]  stop_half_bits;
  ulc_par_t    par_mode;
  logic [15:0] baud_divisor;
  int          bad_count = 0;
  int          tests_run = 0;
  logic [7:0]  rxl [12] = '{8'h01, 8'h04, 8'h08, 8'h0e, 8'h08, 8'h10,
                            8'h18, 8'h1c, 8'h08, 8'h10, 8'h38, 8'h3c};
  logic [7:0]  txl [12] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h10, 8'h08,
                            8'h18, 8'h1e, 8'h08, 8'h10, 8'h20, 8'h38};
  logic [7:0]  tcs [5] = '{8'd0, 8'd20, 8'd10, 8'd0, 8'd10};
  logic [4:0]  req_exp = 5'b01101;

  ulc_top #(.LW(8)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_hold_data(rx_hold), .rx_pop(),
    .tx_push(tx_push), .tx_push_data(tx_push_data),
    .tx_fifo_count(tx_cnt), .rx_fifo_count(rx_cnt),
    .fifo_enable(fifo_enable), .rx_fifo_clear(), .tx_fifo_clear(),
    .tx_trig_req(tx_trig_req), .rx_trig_hit(rx_trig_hit),
    .word_bits(word_bits), .stop_half_bits(stop_half_bits),
    .par_mode(par_mode), .tx_char(tx_char), .tx_par_bit(tx_par_bit),
    .rx_char(rx_char), .rx_par_bit(rx_par_bit), .rx_par_err(rx_par_err),
    .baud_divisor(baud_divisor), .tx_serial_bit(tx_serial_bit),
    .tx_line(tx_line), .dtr_n(dtr_n), .rts_n(rts_n)
  );
  ulc_remote_model i_remote (
    .clk_sys(clk_sys), .word_bits(word_bits), .par_mode(par_mode),
    .corrupt(corrupt), .rx_char(rx_char), .rx_par_bit(rx_par_bit),
    .tx_serial_bit(tx_serial_bit)
  );

  always #20 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input string s, input logic [3:0] a, logic [7:0] e);
    rd(a, rd_v);
    check(s, {8'h00, rd_v}, {8'h00, e});
  endtask
  function automatic logic par_exp(input logic [7:0] l, c);
    logic o;
    o = ^(c & (8'hff >> (2'h3 - l[1:0])));
    if (l[5]) return ~l[4];
    return l[4] ? o : ~o;
  endfunction
  function automatic ulc_par_t mode_exp(input logic [7:0] l);
    if (!l[3]) return ULC_PAR_NONE;
    if (l[5]) return l[4] ? ULC_PAR_SPACE : ULC_PAR_MARK;
    return l[4] ? ULC_PAR_EVEN : ULC_PAR_ODD;
  endfunction
  task automatic give_verdict();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h6c95));
    tick(11);
    check("pins", 16'({tx_line, rts_n, dtr_n}), 16'h0007);
    @(posedge clk_sys);
    rst <= 1'b0;
    rdc("line", 4'h3, 8'h00);
    rdc("modem", 4'h4, 8'h00);
    rdc("unmapped", 4'hf, 8'h00);
    for (int i = 0; i < 16; i++) begin
      v = {2'b00, 3'(i), 3'($urandom)};
      tx_char <= 8'($urandom);
      corrupt <= i[3];
      wr(4'h3, v);
      check("word", 16'(word_bits), 16'(5 + v[1:0]));
      check("stop", 16'(stop_half_bits),
            !v[2] ? 16'h2 : (v[1:0] == 0 ? 16'h3 : 16'h4));
      check("mode", 16'(par_mode), 16'(mode_exp(v)));
      check("rx_err", 16'(rx_par_err), 16'(v[3] & i[3]));
      if (v[3]) check("tx_par", 16'(tx_par_bit),
                      16'(par_exp(v, tx_char)));
      rdc("line", 4'h3, v);
    end
    wr(4'h3, 8'h40);
    repeat (3) begin
      tick(1);
      check("break", 16'(tx_line), 16'h0000);
    end
    v = 8'($urandom);
    wr(4'h3, 8'h80);
    wr(4'h0, v);
    wr(4'h1, ~v);
    tick(1);
    check("divisor", baud_divisor, {~v, v});
    rdc("div_high", 4'h1, ~v);
    wr(4'h3, 8'h00);
    rdc("div_off", 4'h1, 8'h00);
    rx_hold <= v;
    rdc("data", 4'h0, v);
    wr(4'h0, 8'h5a);
    check("push", 16'({tx_push, tx_push_data}), 16'h015a);
    wr(4'h9, 8'h10);
    for (int t = 0; t < 3; t++) begin
      for (int c = 0; c < 4; c++) begin
        wr(4'h2, {2'(c), 2'(3 - c), 4'h7});
        wr(4'h8, {2'(t), 6'h00});
        rdc("rx_lvl", 4'he, rxl[t * 4 + c]);
        rdc("tx_lvl", 4'hd, txl[t * 4 + 3 - c]);
      end
    end
    v = 8'($urandom);
    wr(4'h8, 8'hc0);
    wr(4'ha, v);
    wr(4'hb, ~v);
    rdc("rx_prog", 4'he, v);
    rdc("tx_prog", 4'hd, ~v);
    wr(4'h8, 8'h40);
    wr(4'h2, 8'h01);
    wr(4'h9, 8'h00);
    wr(4'h2, 8'hb9);
    rdc("tx_locked", 4'hd, 8'h10);
    rdc("rx_open", 4'he, 8'h18);
    rd(4'hc, rd_v);
    check("block", 16'(rd_v[1:0]), 16'h0003);
    wr(4'h2, 8'h06);
    tick(1);
    check("fifo_off", 16'(fifo_enable), 16'h0000);
    rdc("rx_kept", 4'he, 8'h18);
    wr(4'h9, 8'h10);
    wr(4'h2, 8'h01);
    for (int k = 0; k < 5; k++) begin
      tx_cnt <= tcs[k];
      rx_cnt <= 8'($urandom % 16);
      tick(3);
      check("tx_req", 16'(tx_trig_req), 16'(req_exp[k]));
      check("rx_hit", 16'(rx_trig_hit), 16'(rx_cnt >= 8));
    end
    wr(4'h9, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(4'h4, 8'(m));
      tick(1);
      check("pins", 16'({rts_n, dtr_n}), 16'(~m & 3));
      rdc("modem", 4'h4, 8'(m));
    end
    wr(4'h9, 8'h40);
    for (int k = 0; k < 4; k++) begin
      rx_cnt <= k[0] ? 8'(8 + $urandom % 8) : 8'($urandom % 8);
      wr(4'h4, k[1] ? 8'h04 : 8'h03);
      tick(1);
      check("auto", 16'({rts_n, dtr_n}), k[1] ? 16'({1'b1, k[0]}) :
            16'({k[0], 1'b0}));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
